// >>> rtl/gpd_map.svh
// register offsets, field masks and reset values of the gpio
// direction and pullup block.
// assumes a 32-bit ahb-lite slot with word-aligned registers.
//
// Behaviour
// [RULE1] One direction bit per port B pin 32 to 38 acts only while that pin is in gpio use.
// [RULE2] A port B direction bit of 0 makes an input, the reset value, and 1 an output.
// [RULE3] Reading port B direction gives the stored settings, not the pin levels.
// [RULE4] Analog-shared pins have direction bits that act only in digital use and read back as stored.
// [RULE5] An analog-shared direction bit of 0 makes an input, the default, and 1 an output.
// [RULE6] Only analog direction bits 2, 4, 6, 10, 12 and 14 are writable; the rest read zero.
// [RULE7] While the external reset is low the pullups of pins 0 to 11 are off at once.
// [RULE8] Reset turns on the pullups of all pins other than 0 to 11.
// [RULE9] After reset every pullup keeps its default until software writes a new one.
// [RULE10] A pullup setting applies whether the pin is in gpio use or peripheral use.
// [RULE11] The port A pullup register has one bit per pin, bit n for pin n, over 32 bits.
// [RULE12] A port A pullup bit of 0 turns the pullup on and 1 turns it off.
// [RULE13] Port A pullup resets to 1 for pins 0 to 11 and to 0 for pins 12 to 31.
// [RULE14] Writes to port B direction and port A pullup are ignored unless protected writes are enabled.
// [RULE15] A direction bit has no effect on a pin given to a peripheral function.
`ifndef GPD_MAP_SVH
`define GPD_MAP_SVH

// ============================================================
// addressing
`define GPD_IDX_W            6
`define GPD_IDX_PULLUP       6'h00
`define GPD_IDX_PORTB_DIR    6'h01
`define GPD_IDX_ANALOG_DIR   6'h02
`define GPD_IDX_PROTECT      6'h03
`define GPD_IDX_PAD_STATUS   6'h04

// ============================================================
// field masks
`define GPD_PORTB_MASK       32'h0000_007f
`define GPD_ANALOG_MASK      32'h0000_5454
`define GPD_PROTECT_MASK     32'h0000_0001
`define GPD_PROTECT_BIT      0
`define GPD_STAT_ANALOG_LSB  16

// ============================================================
// reset values
`define GPD_PULLUP_RST       32'h0000_0fff
`define GPD_PORTB_DIR_RST    32'h0000_0000
`define GPD_ANALOG_DIR_RST   32'h0000_0000
`define GPD_PROTECT_RST      32'h0000_0000

// ============================================================
// bus codes
`define GPD_HSIZE_WORD       3'h2
`define GPD_HRESP_OKAY       1'h0

`endif

// >>> rtl/gpd_pkg.sv
// types shared by the gpio direction and pullup block.
// assumes the map header is included by every user.
package gpd_pkg;

    // ============================================================
    // data-phase state of the bus slave
    typedef enum logic [1:0] {
        phase_idle,
        phase_write,
        phase_read
    } gpd_phase_type;

    typedef logic [31:0] gpd_word_type;

endpackage : gpd_pkg

// >>> rtl/gpd_ahb_if.sv
// ahb-lite address/data phase tracker for the gpio config block.
// assumes one slave, zero wait states, single word transfers.
`timescale 1ns/100ps
`include "gpd_map.svh"

module gpd_ahb_if
    import gpd_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic                  hready,
    output logic                       rd_take,
    output logic [`GPD_IDX_W-1:0]      rd_idx,
    output logic                       wr_commit,
    output logic [`GPD_IDX_W-1:0]      wr_idx
);

    gpd_phase_type             phase_r;
    logic [`GPD_IDX_W-1:0]     idx_r;
    logic                      take;

    // non-word sizes are not taken and so do nothing
    assign take = hsel & htrans[1] & hready & (hsize == `GPD_HSIZE_WORD);
    assign rd_take = take & ~hwrite;
    assign rd_idx = haddr[`GPD_IDX_W+1:2];
    assign wr_commit = (phase_r == phase_write);
    assign wr_idx = idx_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= phase_idle;
        end else if (hready) begin
            if (take && hwrite) begin
                phase_r <= phase_write;
            end else if (take) begin
                phase_r <= phase_read;
            end else begin
                phase_r <= phase_idle;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_r <= '0;
        end else if (take) begin
            idx_r <= haddr[`GPD_IDX_W+1:2];
        end
    end

endmodule : gpd_ahb_if

// >>> rtl/gpd_pad_ctrl.sv
// registered pad controls: output enables and pullup disables.
// assumes mux selects come from the pin-function logic elsewhere.
`timescale 1ns/100ps
`include "gpd_map.svh"

module gpd_pad_ctrl
    import gpd_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic [31:0]   pullup_cfg,
    input  wire logic [6:0]    portb_dir,
    input  wire logic [6:0]    portb_gpio_sel,
    input  wire logic [15:0]   analog_dir,
    input  wire logic [15:0]   analog_gpio_sel,
    output logic [31:0]        port_a_pullup_off,
    output logic [6:0]         port_b_out_en,
    output logic [15:0]        analog_out_en
);

    // reset value forces pins 0..11 off without a clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_a_pullup_off <= `GPD_PULLUP_RST; // [RULE7] [RULE8]
        end else begin
            // no mux term: pullup follows config in every mode
            port_a_pullup_off <= pullup_cfg; // [RULE10] [RULE12]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_b_out_en <= '0;
            analog_out_en <= '0;
        end else begin
            port_b_out_en <= portb_dir & portb_gpio_sel; // [RULE1] [RULE15]
            analog_out_en <= analog_dir & analog_gpio_sel; // [RULE4]
        end
    end

endmodule : gpd_pad_ctrl

// >>> rtl/gpd_top.sv
// gpio direction and pullup configuration block, ahb-lite slave.
// assumes a single ahb-lite master; the slave never inserts waits.
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "gpd_map.svh"

module gpd_top
    import gpd_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic          hready,
    input  wire logic [31:0]   hwdata,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic [6:0]    portb_gpio_sel,
    input  wire logic [15:0]   analog_gpio_sel,
    output logic [31:0]        port_a_pullup_off,
    output logic [6:0]         port_b_out_en,
    output logic [15:0]        analog_out_en
);

    // ============================================================
    // helpers
    function automatic gpd_word_type masked_write(
        input gpd_word_type old_val,
        input gpd_word_type new_val,
        input gpd_word_type mask
    );
        masked_write = (new_val & mask) | (old_val & ~mask);
    endfunction : masked_write

    // ============================================================
    // signals
    logic                      rd_take;
    logic [`GPD_IDX_W-1:0]     rd_idx;
    logic                      wr_commit;
    logic [`GPD_IDX_W-1:0]     wr_idx;

    gpd_word_type              port_a_pullup_disable_r;
    gpd_word_type              port_a_pullup_disable_nxt;
    gpd_word_type              port_b_direction_r;
    gpd_word_type              port_b_direction_nxt;
    gpd_word_type              analog_pin_direction_r;
    gpd_word_type              analog_pin_direction_nxt;
    gpd_word_type              protect_r;
    gpd_word_type              protect_nxt;
    gpd_word_type              pad_status;
    gpd_word_type              rd_value;
    logic                      protected_write_enable;

    logic [31:0]               hrdata_r;
    logic                      hreadyout_r;
    logic                      hresp_r;

    // ============================================================
    // bus phase tracking
    gpd_ahb_if u_ahb_if (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .rd_take   (rd_take),
        .rd_idx    (rd_idx),
        .wr_commit (wr_commit),
        .wr_idx    (wr_idx)
    );

    assign protected_write_enable = protect_r[`GPD_PROTECT_BIT];

    // ============================================================
    // next values of the register file
    always_comb begin
        protect_nxt = protect_r;
        if (wr_commit && wr_idx == `GPD_IDX_PROTECT) begin
            protect_nxt = masked_write(protect_r, hwdata,
                                       `GPD_PROTECT_MASK);
        end
    end

    // pullups only change on a granted write
    always_comb begin
        port_a_pullup_disable_nxt = port_a_pullup_disable_r; // [RULE9]
        if (wr_commit && wr_idx == `GPD_IDX_PULLUP &&
            protected_write_enable) begin // [RULE14]
            port_a_pullup_disable_nxt = hwdata; // [RULE11]
        end
    end

    always_comb begin
        port_b_direction_nxt = port_b_direction_r;
        if (wr_commit && wr_idx == `GPD_IDX_PORTB_DIR &&
            protected_write_enable) begin // [RULE14]
            port_b_direction_nxt = masked_write(port_b_direction_r,
                                                hwdata,
                                                `GPD_PORTB_MASK); // [RULE2]
        end
    end

    // analog direction is not behind the protection bit
    always_comb begin
        analog_pin_direction_nxt = analog_pin_direction_r;
        if (wr_commit && wr_idx == `GPD_IDX_ANALOG_DIR) begin
            analog_pin_direction_nxt =
                masked_write(analog_pin_direction_r, hwdata,
                             `GPD_ANALOG_MASK); // [RULE6] [RULE5]
        end
    end

    // ============================================================
    // register storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            protect_r <= `GPD_PROTECT_RST;
        end else begin
            protect_r <= protect_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_a_pullup_disable_r <= `GPD_PULLUP_RST; // [RULE13]
        end else begin
            port_a_pullup_disable_r <= port_a_pullup_disable_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_b_direction_r <= `GPD_PORTB_DIR_RST; // [RULE2]
        end else begin
            port_b_direction_r <= port_b_direction_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_pin_direction_r <= `GPD_ANALOG_DIR_RST; // [RULE5]
        end else begin
            analog_pin_direction_r <= analog_pin_direction_nxt;
        end
    end

    // ============================================================
    // pad drive
    gpd_pad_ctrl u_pad_ctrl (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .pullup_cfg        (port_a_pullup_disable_r),
        .portb_dir         (port_b_direction_r[6:0]),
        .portb_gpio_sel    (portb_gpio_sel),
        .analog_dir        (analog_pin_direction_r[15:0]),
        .analog_gpio_sel   (analog_gpio_sel),
        .port_a_pullup_off (port_a_pullup_off),
        .port_b_out_en     (port_b_out_en),
        .analog_out_en     (analog_out_en)
    );

    // effective enables as driven to the pads
    always_comb begin
        pad_status = '0;
        pad_status[6:0] = port_b_out_en;
        pad_status[`GPD_STAT_ANALOG_LSB +: 16] = analog_out_en;
    end

    // ============================================================
    // read path
    // reads see the next values so a write followed at once by a
    // read of the same word returns the new setting
    always_comb begin
        case (rd_idx)
            `GPD_IDX_PULLUP: begin
                rd_value = port_a_pullup_disable_nxt;
            end
            `GPD_IDX_PORTB_DIR: begin
                rd_value = port_b_direction_nxt; // [RULE3]
            end
            `GPD_IDX_ANALOG_DIR: begin
                rd_value = analog_pin_direction_nxt; // [RULE4]
            end
            `GPD_IDX_PROTECT: begin
                rd_value = protect_nxt;
            end
            `GPD_IDX_PAD_STATUS: begin
                rd_value = pad_status;
            end
            default: begin
                rd_value = '0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (rd_take) begin
            hrdata_r <= rd_value;
        end else begin
            hrdata_r <= '0;
        end
    end

    // zero-wait slave; kept in flops so outputs are registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hresp_r     <= `GPD_HRESP_OKAY;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= `GPD_HRESP_OKAY;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;

endmodule : gpd_top

// >>> sim/gpd_pads.sv
// pad model: pin levels set by the port a pullup controls.
// assumes the pullup controls come straight from gpd_top.
`timescale 1ns/100ps
module gpd_pads (
    input  wire logic [31:0] port_a_pullup_off,
    output logic      [31:0] pa_level
);
    // ========
    // pins
    // a pin without its pull floats; it sinks low, never high
    always_comb pa_level = ~port_a_pullup_off;
endmodule : gpd_pads

// >>> sim/gpd_top_assertions.sv
// port checks for the gpio direction and pullup block.
// assumes hready is fed back from hreadyout.
`timescale 1ns/100ps
module gpd_top_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [6:0]  portb_gpio_sel,
    input wire logic [15:0] analog_gpio_sel,
    input wire logic [31:0] port_a_pullup_off,
    input wire logic [6:0]  port_b_out_en,
    input wire logic [15:0] analog_out_en
);
    // ========
    // helpers
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_take;
    logic wr_take;
    assign rd_take = hsel & htrans[1] & hready & !hwrite;
    assign wr_take = hsel & htrans[1] & hready & hwrite;
    // ========
    // checks
    rdy_okay_a: assert property (hreadyout && !hresp)
        else $error("slave stalled or gave an error");
    rdata_idle_a: assert property (!$past(rd_take) |-> hrdata == 0)
        else $error("read data outside a data phase");
    pb_gpio_only_a: assert property (
        (port_b_out_en & ~$past(portb_gpio_sel)) == 7'h00)
        else $error("port b driven while not in gpio use");
    an_gpio_only_a: assert property (
        (analog_out_en & ~$past(analog_gpio_sel)) == 16'h0000)
        else $error("analog pin driven while not in gpio use");
    an_bits_a: assert property ((analog_out_en & 16'habab) == 0)
        else $error("analog pin without direction bit driven");
    pull_rst_a: assert property (disable iff (1'b0)
        !hresetn |-> port_a_pullup_off == 32'h0000_0fff)
        else $error("pullups wrong during reset");
    pull_hold_a: assert property (
        $changed(port_a_pullup_off) |-> $past(wr_take, 3))
        else $error("pullup changed without a write");
    pull_value_a: assert property (
        $changed(port_a_pullup_off) |-> port_a_pullup_off == $past(hwdata, 2))
        else $error("pullup differs from written word");
    cover property (wr_take);
    cover property (rd_take);
    cover property ($changed(port_a_pullup_off));
endmodule : gpd_top_assertions
bind gpd_top gpd_top_assertions u_chk (.*);

// >>> sim/tb_gpd_top.sv
// self-checking bench for gpd_top over ahb-lite.
// assumes zero-wait slave answers and the pad model beside it.
`timescale 1ns/100ps
module tb_gpd_top;
    // ========
    // signals
    logic        hclk = 1'b0;
    logic        hresetn = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        rd_ph = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [6:0]  pb_sel = '0;
    logic [15:0] an_sel = '0;
    logic [31:0] hrdata, pull_off, pa_level, r, d;
    logic [6:0]  pb_oe;
    logic [15:0] an_oe;
    logic        hreadyout, hresp;
    logic [31:0] exp_q[$];
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    always #2 hclk = ~hclk;
    gpd_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .portb_gpio_sel(pb_sel),
        .analog_gpio_sel(an_sel), .port_a_pullup_off(pull_off),
        .port_b_out_en(pb_oe), .analog_out_en(an_oe));
    gpd_pads u_pads (.port_a_pullup_off(pull_off),
        .pa_level(pa_level));
    // ========
    // tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] dat);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= dat;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : ahb
    task rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    // ========
    // monitor: read data sits mid data phase
    always @(posedge hclk) rd_ph <= hsel & htrans[1] & !hwrite;
    always @(negedge hclk) begin
        if (rd_ph) begin
            chk(hrdata, exp_q.pop_front());
        end
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            results();
        end
    end
    // ========
    // scenarios
    initial begin
        void'($urandom(32'h4b11));
        // a real falling edge, so the pullups are forced before any clock
        #1;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        #1;
        chk(pull_off, 32'h0000_0fff);
        hresetn = 1'b1;
        @(posedge hclk);
        rd(32'h0000_0000, 32'h0000_0fff);
        rd(32'h0000_0004, 32'h0000_0000);
        rd(32'h0000_0008, 32'h0000_0000);
        chk(pa_level | 32'h0000_0fff, 32'hffff_ffff);
        r = $urandom();
        ahb(1'b1, 32'h0000_0000, r);
        ahb(1'b1, 32'h0000_0004, 32'h0000_007f);
        ahb(1'b1, 32'h0000_0008, 32'hffff_ffff);
        rd(32'h0000_0000, 32'h0000_0fff);
        rd(32'h0000_0004, 32'h0000_0000);
        rd(32'h0000_0008, 32'h0000_5454);
        hsize <= 3'h0;
        ahb(1'b1, 32'h0000_0008, 32'h0000_0000);
        hsize <= 3'h2;
        rd(32'h0000_0008, 32'h0000_5454);
        rd(32'h0000_0020, 32'h0000_0000);
        ahb(1'b1, 32'h0000_000c, 32'h0000_0001);
        ahb(1'b1, 32'h0000_0000, r);
        rd(32'h0000_0000, r);
        #1;
        chk(pull_off, r);
        chk(pa_level, ~r);
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            d = $urandom();
            ahb(1'b1, 32'h0000_0004, d);
            ahb(1'b1, 32'h0000_0008, d);
            pb_sel <= 7'($urandom());
            an_sel <= 16'($urandom());
            rd(32'h0000_0004, d & 32'h0000_007f);
            rd(32'h0000_0008, d & 32'h0000_5454);
            #1;
            chk({25'h0, pb_oe}, {25'h0, d[6:0] & pb_sel});
            chk({16'h0, an_oe}, {16'h0, d[15:0] & 16'h5454 & an_sel});
            @(posedge hclk);
            rd(32'h0000_0010, {d[15:0] & 16'h5454 & an_sel, 9'h0,
                d[6:0] & pb_sel});
        end
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        @(posedge hclk);
        #1;
        chk(pull_off, 32'h0000_0000);
        hresetn = 1'b0;
        #1;
        chk(pull_off, 32'h0000_0fff);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(32'h0000_0000, 32'h0000_0fff);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        rd(32'h0000_0000, 32'h0000_0fff);
        results();
    end
endmodule : tb_gpd_top
